/* inc/spcfg_pkg.sv */
// Constants for the serial-port configuration and stored-memory control bank.
// Assumes a serial engine that delivers whole bytes with an address.
package spcfg_pkg;
   localparam int unsigned ADDR_W           = 12;
   localparam logic [11:0] OFS_SERIAL_CFG   = 12'h000;
   localparam logic [11:0] OFS_READBACK_SEL = 12'h004;
   localparam logic [11:0] OFS_NVM_STATUS   = 12'hb00;
   localparam logic [11:0] OFS_NVM_ERROR    = 12'hb01;
   localparam logic [11:0] OFS_NVM_CTRL_ONE = 12'hb02;
   localparam logic [11:0] OFS_NVM_CTRL_TWO = 12'hb03;
   localparam int unsigned BIT_PORT_DIR     = 7;
   localparam int unsigned BIT_LSB_FIRST    = 6;
   localparam int unsigned BIT_SOFT_RESET   = 5;
   localparam int unsigned BIT_UNUSED4      = 4;
   localparam int unsigned BIT_READ_ACTIVE  = 0;
   localparam int unsigned BIT_NVM_STATUS   = 0;
   localparam int unsigned BIT_NVM_DATA_ERR = 0;
   localparam int unsigned BIT_NVM_LOAD     = 1;
   localparam int unsigned BIT_NVM_WR_EN    = 0;
   localparam int unsigned BIT_NVM_STORE    = 0;
   localparam logic [7:0]  RST_SERIAL_CFG   = 8'h00;
   localparam logic [7:0]  RST_READBACK_SEL = 8'h00;
   localparam logic [7:0]  RST_NVM          = 8'h00;
   localparam logic [7:0]  READ_UNMAPPED    = 8'h00;
   typedef enum logic [1:0] {
      SR_IDLE  = 2'b00,
      SR_WAIT  = 2'b01,
      SR_APPLY = 2'b11
   } srst_state_type;
endpackage : spcfg_pkg

/* verilog/serial_port_config_nvm_control_regs.sv */
// Configuration bank behind the serial control port and memory control.
// Assumes the serial engine gives one write or read strobe per byte,
// i_sclk_tick once per serial clock (SCLK or SCL), and a memory sequencer.
`timescale 1ns/10ps
module serial_port_config_nvm_control_regs
   import spcfg_pkg::*;
(
   input  wire logic              i_ref_clk,
   input  wire logic              i_srst,
   input  wire logic              i_i2c_mode,
   input  wire logic              i_sclk_tick,
   input  wire logic              i_wr_stb,
   input  wire logic              i_rd_stb,
   input  wire logic [ADDR_W-1:0] i_addr,
   input  wire logic [7:0]        i_wdata,
   input  wire logic              i_nvm_status,
   input  wire logic              i_nvm_data_error,
   input  wire logic              i_nvm_load_done,
   input  wire logic              i_nvm_store_done,
   output logic [7:0]             o_rdata,
   output logic                   o_rd_valid,
   output logic                   o_use_serial_out_pin,
   output logic                   o_lsb_first,
   output logic                   o_addr_incr,
   output logic                   o_read_active,
   output logic                   o_soft_reset,
   output logic                   o_nvm_write_enable,
   output logic                   o_nvm_load_start,
   output logic                   o_nvm_store_start
);
   logic [7:0]     serial_cfg;
   logic [7:0]     next_serial_cfg;
   logic           read_active;
   logic           next_read_active;
   logic           nvm_wr_en;
   logic           next_nvm_wr_en;
   logic           load_busy;
   logic           next_load_busy;
   logic           store_busy;
   logic           next_store_busy;
   logic           nvm_status;
   logic           nvm_error;
   srst_state_type sr_state;
   srst_state_type next_sr_state;
   logic [7:0]     next_rdata;
   logic           wr_cfg;
   logic           wr_load;
   logic           wr_store;

   assign wr_cfg   = i_wr_stb && (i_addr == OFS_SERIAL_CFG);
   assign wr_load  = i_wr_stb && (i_addr == OFS_NVM_CTRL_ONE)
                     && i_wdata[BIT_NVM_LOAD];
   assign wr_store = i_wr_stb && (i_addr == OFS_NVM_CTRL_TWO)
                     && i_wdata[BIT_NVM_STORE];

   // Soft reset sequencing
   always_comb begin
      next_sr_state = sr_state;
      case (sr_state)
         SR_IDLE: begin
            if (wr_cfg && i_wdata[BIT_SOFT_RESET]) begin
               next_sr_state = SR_WAIT;
            end
         end
         SR_WAIT: begin
            if (i_sclk_tick) begin
               next_sr_state = SR_APPLY;
            end
         end
         SR_APPLY: next_sr_state = SR_IDLE;
         default:  next_sr_state = SR_IDLE;
      endcase
   end

   // Register writes and defaults
   always_comb begin
      next_serial_cfg  = serial_cfg;
      next_read_active = read_active;
      next_nvm_wr_en   = nvm_wr_en;
      next_load_busy   = load_busy;
      next_store_busy  = store_busy;
      // busy cleared by done, set wins
      if (i_nvm_load_done) begin
         next_load_busy = 1'b0;
      end
      if (i_nvm_store_done) begin
         next_store_busy = 1'b0;
      end
      if (i_wr_stb) begin
         case (i_addr)
            OFS_SERIAL_CFG: begin
               next_serial_cfg = i_wdata;
               next_serial_cfg[BIT_UNUSED4] = 1'b0;
            end
            OFS_READBACK_SEL: next_read_active = i_wdata[BIT_READ_ACTIVE];
            OFS_NVM_CTRL_ONE: next_nvm_wr_en = i_wdata[BIT_NVM_WR_EN];
            default: ;
         endcase
      end
      if (wr_load) begin
         next_load_busy = 1'b1;
      end
      if (wr_store) begin
         next_store_busy = 1'b1;
      end
      if (sr_state == SR_APPLY) begin
         next_serial_cfg  = RST_SERIAL_CFG;
         next_read_active = RST_READBACK_SEL[BIT_READ_ACTIVE];
         next_nvm_wr_en   = RST_NVM[BIT_NVM_WR_EN];
         next_load_busy   = RST_NVM[BIT_NVM_LOAD];
         next_store_busy  = RST_NVM[BIT_NVM_STORE];
      end
   end

   // Readback mux
   always_comb begin
      next_rdata = READ_UNMAPPED;
      case (i_addr)
         OFS_SERIAL_CFG: begin
            next_rdata = serial_cfg;
            next_rdata[BIT_SOFT_RESET] = (sr_state != SR_IDLE);
         end
         OFS_READBACK_SEL: next_rdata[BIT_READ_ACTIVE] = read_active;
         OFS_NVM_STATUS:   next_rdata[BIT_NVM_STATUS] = nvm_status;
         OFS_NVM_ERROR:    next_rdata[BIT_NVM_DATA_ERR] = nvm_error;
         OFS_NVM_CTRL_ONE: begin
            next_rdata[BIT_NVM_LOAD]  = load_busy;
            next_rdata[BIT_NVM_WR_EN] = nvm_wr_en;
         end
         OFS_NVM_CTRL_TWO: next_rdata[BIT_NVM_STORE] = store_busy;
         default: ;
      endcase
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         sr_state             <= SR_IDLE;
         serial_cfg           <= RST_SERIAL_CFG;
         read_active          <= 1'b0;
         nvm_wr_en            <= 1'b0;
         load_busy            <= 1'b0;
         store_busy           <= 1'b0;
         nvm_status           <= 1'b0;
         nvm_error            <= 1'b0;
         o_rdata              <= 8'h00;
         o_rd_valid           <= 1'b0;
         o_use_serial_out_pin <= 1'b0;
         o_lsb_first          <= 1'b0;
         o_addr_incr          <= 1'b0;
         o_read_active        <= 1'b0;
         o_soft_reset         <= 1'b0;
         o_nvm_write_enable   <= 1'b0;
         o_nvm_load_start     <= 1'b0;
         o_nvm_store_start    <= 1'b0;
      end else begin
         sr_state             <= next_sr_state;
         serial_cfg           <= next_serial_cfg;
         read_active          <= next_read_active;
         nvm_wr_en            <= next_nvm_wr_en;
         load_busy            <= next_load_busy;
         store_busy           <= next_store_busy;
         nvm_status           <= i_nvm_status;
         nvm_error            <= i_nvm_data_error;
         o_rdata              <= i_rd_stb ? next_rdata : o_rdata;
         o_rd_valid           <= i_rd_stb;
         // serial out pin only when selected
         o_use_serial_out_pin <= next_serial_cfg[BIT_PORT_DIR]
                                 && !i_i2c_mode;
         o_lsb_first          <= next_serial_cfg[BIT_LSB_FIRST]
                                 && !i_i2c_mode;
         o_addr_incr          <= next_serial_cfg[BIT_LSB_FIRST]
                                 && !i_i2c_mode;
         o_read_active        <= next_read_active;
         o_soft_reset         <= (next_sr_state == SR_APPLY);
         o_nvm_write_enable   <= next_nvm_wr_en;
         o_nvm_load_start     <= wr_load && !load_busy;
         o_nvm_store_start    <= wr_store && !store_busy;
      end
   end

   chk_dir_default: assert property (
      @(posedge i_ref_clk) disable iff (i_srst)
      !serial_cfg[BIT_PORT_DIR] ##1 !serial_cfg[BIT_PORT_DIR]
      |-> !o_use_serial_out_pin)
      else $error("serial out pin used with direction bit clear");

   chk_msb_first: assert property (
      @(posedge i_ref_clk) disable iff (i_srst)
      !next_serial_cfg[BIT_LSB_FIRST] |=> !o_lsb_first && !o_addr_incr)
      else $error("bit order not MSB first with decrement");

   chk_lsb_first: assert property (
      @(posedge i_ref_clk) disable iff (i_srst)
      next_serial_cfg[BIT_LSB_FIRST] && !i_i2c_mode
      |=> o_lsb_first && o_addr_incr)
      else $error("bit order not LSB first with increment");

   chk_i2c_order: assert property (
      @(posedge i_ref_clk) disable iff (i_srst)
      i_i2c_mode |=> !o_lsb_first && !o_addr_incr && !o_use_serial_out_pin)
      else $error("bit order applied in I2C mode");

   // Pulse stands in the apply cycle, registers clear after it
   chk_srst_defaults: assert property (
      @(posedge i_ref_clk) disable iff (i_srst)
      sr_state == SR_APPLY |-> o_soft_reset ##1 (serial_cfg == RST_SERIAL_CFG
      && !read_active && !nvm_wr_en && !load_busy && !store_busy))
      else $error("soft reset did not restore defaults");

   chk_srst_arm: assert property (
      @(posedge i_ref_clk) disable iff (i_srst)
      sr_state == SR_IDLE && wr_cfg && i_wdata[BIT_SOFT_RESET]
      ##1 !i_sclk_tick |=> sr_state == SR_WAIT)
      else $error("soft reset bit cleared before next serial clock");

   chk_srst_clear: assert property (
      @(posedge i_ref_clk) disable iff (i_srst)
      sr_state == SR_WAIT && i_sclk_tick |=> sr_state == SR_APPLY ##1
      sr_state == SR_IDLE && !o_soft_reset)
      else $error("soft reset bit did not self clear");

   chk_readback_sel: assert property (
      @(posedge i_ref_clk) disable iff (i_srst)
      i_wr_stb && i_addr == OFS_READBACK_SEL && sr_state != SR_APPLY
      |=> o_read_active == $past(i_wdata[BIT_READ_ACTIVE]))
      else $error("readback source does not follow select bit");

   chk_store_busy: assert property (
      @(posedge i_ref_clk) disable iff (i_srst)
      wr_store && sr_state != SR_APPLY |=> store_busy)
      else $error("store trigger not shown busy");

   chk_store_hold: assert property (
      @(posedge i_ref_clk) disable iff (i_srst)
      store_busy && !i_nvm_store_done && sr_state != SR_APPLY |=> store_busy)
      else $error("store trigger dropped while busy");

   chk_load_done: assert property (
      @(posedge i_ref_clk) disable iff (i_srst)
      i_nvm_load_done && !wr_load |=> !load_busy)
      else $error("load trigger not cleared on completion");
endmodule : serial_port_config_nvm_control_regs

/* test/spcfg_host_model.sv */
// Far-side model: serial clock ticks and the memory sequencer.
// Assumes start pulses from the bank; ticks only while a frame runs.
`timescale 1ns/10ps
module spcfg_host_model #(
   parameter int DONE_DLY = 8
) (
   input  wire logic i_ref_clk,
   input  wire logic i_tick_en,
   input  wire logic i_load_start,
   input  wire logic i_store_start,
   output logic      o_tick,
   output logic      o_load_done,
   output logic      o_store_done
);
   int tick_cnt  = 0;
   int load_cnt  = 0;
   int store_cnt = 0;
   initial begin
      o_tick = 1'b0;
      o_load_done = 1'b0;
      o_store_done = 1'b0;
   end
   always @(posedge i_ref_clk) begin
      tick_cnt <= i_tick_en ? (tick_cnt + 1) % 4 : 0;
      o_tick <= #1 i_tick_en && tick_cnt == 3;
      load_cnt <= i_load_start ? DONE_DLY : (load_cnt > 0 ? load_cnt - 1 : 0);
      store_cnt <= i_store_start ? DONE_DLY
                   : (store_cnt > 0 ? store_cnt - 1 : 0);
      o_load_done <= #1 load_cnt == 1;
      o_store_done <= #1 store_cnt == 1;
   end
endmodule : spcfg_host_model

/* test/serial_port_config_nvm_control_regs_tb.sv */
// Bench for the serial-port configuration and memory control bank.
// Assumes the far-side model supplies ticks and done pulses.
`timescale 1ns/10ps
module serial_port_config_nvm_control_regs_tb;
   import spcfg_pkg::*;
   logic i_ref_clk = 0, i_srst = 1, i_i2c_mode = 0, tick_en = 0;
   logic i_wr_stb = 0, i_rd_stb = 0, i_nvm_status = 0, i_nvm_data_error = 0;
   logic [ADDR_W-1:0] i_addr = '0;
   logic [7:0] i_wdata = 8'h00, o_rdata;
   logic tick, ld_done, st_done, o_rd_valid, o_use_serial_out_pin;
   logic o_lsb_first, o_addr_incr, o_read_active, o_soft_reset;
   logic o_nvm_write_enable, o_nvm_load_start, o_nvm_store_start;
   int fails = 0, compares = 0, cyc_n = 0, sr_n = 0, ld_n = 0, st_n = 0;
   int n, m;
   logic [11:0] offs [7] = '{12'h000, 12'h004, 12'hb00, 12'hb01,
                              12'hb02, 12'hb03, 12'h005};
   always #50 i_ref_clk = ~i_ref_clk;
   serial_port_config_nvm_control_regs u_dut (.i_ref_clk(i_ref_clk),
      .i_srst(i_srst), .i_i2c_mode(i_i2c_mode), .i_sclk_tick(tick),
      .i_wr_stb(i_wr_stb), .i_rd_stb(i_rd_stb), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_nvm_status(i_nvm_status),
      .i_nvm_data_error(i_nvm_data_error), .i_nvm_load_done(ld_done),
      .i_nvm_store_done(st_done), .o_rdata(o_rdata), .o_rd_valid(o_rd_valid),
      .o_use_serial_out_pin(o_use_serial_out_pin), .o_lsb_first(o_lsb_first),
      .o_addr_incr(o_addr_incr), .o_read_active(o_read_active),
      .o_soft_reset(o_soft_reset), .o_nvm_write_enable(o_nvm_write_enable),
      .o_nvm_load_start(o_nvm_load_start),
      .o_nvm_store_start(o_nvm_store_start));
   spcfg_host_model u_host (.i_ref_clk(i_ref_clk), .i_tick_en(tick_en),
      .i_load_start(o_nvm_load_start), .i_store_start(o_nvm_store_start),
      .o_tick(tick), .o_load_done(ld_done), .o_store_done(st_done));
   task automatic summarize;
      if (fails == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : summarize
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask : chk_byte
   task automatic chk_bit(input logic got, input logic exp);
      chk_byte({7'h00, got}, {7'h00, exp});
   endtask : chk_bit
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge i_ref_clk) #1;
      i_wr_stb = 1'b1;
      i_addr = a;
      i_wdata = d;
      @(posedge i_ref_clk) #1;
      i_wr_stb = 1'b0;
      @(posedge i_ref_clk) #1;
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [7:0] e);
      @(posedge i_ref_clk) #1;
      i_rd_stb = 1'b1;
      i_addr = a;
      @(posedge i_ref_clk) #1;
      i_rd_stb = 1'b0;
      chk_bit(o_rd_valid, 1'b1);
      chk_byte(o_rdata, e);
   endtask : rd
   always @(posedge i_ref_clk) begin
      cyc_n++;
      if (o_soft_reset === 1'b1) sr_n++;
      if (o_nvm_load_start === 1'b1) ld_n++;
      if (o_nvm_store_start === 1'b1) st_n++;
      if (cyc_n == 3000) begin
         fails++;
         summarize();
      end
   end
   initial begin
      repeat (10) @(posedge i_ref_clk);
      #1 i_srst = 1'b0;
      foreach (offs[k]) rd(offs[k], 8'h00);
      wr(12'h000, 8'h81);
      chk_bit(o_use_serial_out_pin, 1'b1);
      rd(12'h000, 8'h81);
      wr(12'h000, 8'h42);
      chk_bit(o_lsb_first, 1'b1);
      chk_bit(o_addr_incr, 1'b1);
      wr(12'h000, 8'h00);
      chk_bit(o_lsb_first, 1'b0);
      chk_bit(o_addr_incr, 1'b0);
      chk_bit(o_use_serial_out_pin, 1'b0);
      i_i2c_mode = 1'b1;
      wr(12'h000, 8'hc3);
      chk_bit(o_lsb_first, 1'b0);
      chk_bit(o_addr_incr, 1'b0);
      chk_bit(o_use_serial_out_pin, 1'b0);
      wr(12'h000, 8'h00);
      i_i2c_mode = 1'b0;
      wr(12'h004, 8'h01);
      chk_bit(o_read_active, 1'b1);
      rd(12'h004, 8'h01);
      wr(12'hb02, 8'h01);
      i_nvm_status = 1'b1;
      i_nvm_data_error = 1'b1;
      wr(12'hb00, 8'hff);
      wr(12'hb01, 8'hff);
      rd(12'hb00, 8'h01);
      rd(12'hb01, 8'h01);
      chk_bit(o_nvm_write_enable, 1'b1);
      for (m = 0; m < 2; m++) begin
         i_i2c_mode = m[0];
         wr(12'h004, 8'h01);
         wr(12'h000, 8'h24);
         rd(12'h000, 8'h24);
         chk_byte(8'(sr_n), 8'(m));
         tick_en = 1'b1;
         for (n = 0; n < 20 && sr_n == m; n++) @(posedge i_ref_clk) #1;
         tick_en = 1'b0;
         repeat (2) @(posedge i_ref_clk) #1;
         chk_byte(8'(sr_n), 8'(m + 1));
         rd(12'h004, 8'h00);
         rd(12'h000, 8'h00);
         chk_bit(o_read_active, 1'b0);
         chk_bit(o_nvm_write_enable, 1'b0);
      end
      i_i2c_mode = 1'b0;
      wr(12'hb03, 8'h01);
      wr(12'hb03, 8'h01);
      rd(12'hb03, 8'h01);
      repeat (12) @(posedge i_ref_clk) #1;
      rd(12'hb03, 8'h00);
      chk_byte(8'(st_n), 8'h01);
      wr(12'hb02, 8'h02);
      rd(12'hb02, 8'h02);
      repeat (12) @(posedge i_ref_clk) #1;
      rd(12'hb02, 8'h00);
      chk_byte(8'(ld_n), 8'h01);
      summarize();
   end
endmodule : serial_port_config_nvm_control_regs_tb
